/* verilog/cfg_pkg.sv */
// shared constants and types of the configuration pin controller
package cfg_pkg;
    localparam int WORD_W = 32;
    localparam int DATA_PINS = 32;
    // framing of a load: identifier word, payload words, checksum word
    localparam logic [15:0] PAYLOAD_WORDS_DEF = 16'h0004;
    // identifier expected in the first word; value is arbitrary
    localparam logic [31:0] EXPECTED_ID_DEF = 32'h0A5C_3E71;
    // flash read command and image spacing used in active mode
    localparam logic [7:0] FLASH_READ_CMD = 8'h03;
    localparam logic [23:0] IMAGE_STRIDE = 24'h10_0000;
    localparam int FLASH_CMD_BITS = 32;
    // active clock half period, in nanoseconds and in clock_in cycles
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int CCLK_HALF_NS = 40;
    localparam int CCLK_HALF_CYCLES =
        (CCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // bus width codes; the pulled-up default 3'b111 means x1
    localparam logic [2:0] WIDTH_CODE_MAX = 3'h5;
    // reset values of pin-facing state
    localparam logic ERROR_N_RST = 1'b1;
    localparam logic RESERVED_RST = 1'b1;
    // test access port
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h3;
    localparam logic [IR_W-1:0] IR_STATUS = 4'h5;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam int STATUS_W = 8;
    // tap identity word; value is arbitrary
    localparam logic [31:0] TAP_IDCODE_DEF = 32'h1234_5001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_LOAD = 3'h3,
        ST_CHECK = 3'h2,
        ST_RELEASE = 3'h6,
        ST_USER = 3'h7,
        ST_FAIL = 3'h5
    } cfg_state_t;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6,
        TAP_EXIT1_DR = 4'h7,
        TAP_PAUSE_DR = 4'h5,
        TAP_EXIT2_DR = 4'h4,
        TAP_UPD_DR = 4'hC,
        TAP_SEL_IR = 4'hD,
        TAP_CAP_IR = 4'hF,
        TAP_SHIFT_IR = 4'hE,
        TAP_EXIT1_IR = 4'hA,
        TAP_PAUSE_IR = 4'hB,
        TAP_EXIT2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } tap_state_t;
endpackage : cfg_pkg

/* verilog/tap_link_if.sv */
// status carried from the controller into the test access port
`timescale 1ns/1ps
`default_nettype none
interface tap_link_if;
    logic done_released;
    logic error_seen;
    logic user_mode;
    logic [2:0] state_code;
    modport ctrl (output done_released, error_seen, user_mode, state_code);
    modport tap (input done_released, error_seen, user_mode, state_code);
endinterface : tap_link_if
`default_nettype wire

/* verilog/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // a bit changes only where stages two and three agree
    always_comb
    begin
        level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));
    end

    // first stage feeds the second stage only
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level_reg <= INIT;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule : pin_sync
`default_nettype wire

/* verilog/jtag_tap.sv */
// boundary test access port on the test clock
`timescale 1ns/1ps
`default_nettype none
module jtag_tap
    import cfg_pkg::*;
#(
    parameter logic [31:0] IDCODE = TAP_IDCODE_DEF
) (
    input wire logic tck_in,
    input wire logic rst_in,
    input wire logic tms_in,
    input wire logic tms_driven_in,
    input wire logic tdi_in,
    input wire logic tdi_driven_in,
    tap_link_if.tap link,
    output logic tdo_out,
    output logic tdo_oe_out
);
    tap_state_t st_reg, st_next;
    logic [IR_W-1:0] ir_reg, ir_next, irsh_reg, irsh_next;
    logic [31:0] dr_reg, dr_next;
    logic tms_eff, tdi_eff, shift_bit, tdo_reg, tdo_oe_reg, rst_s;
    logic [STATUS_W-1:0] stat_s;

    assign tms_eff = tms_driven_in ? tms_in : 1'b1;
    assign tdi_eff = tdi_driven_in ? tdi_in : 1'b1;

    // reset and status come from the system clock domain
    pin_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
        .clk_in(tck_in),
        .rst_in(1'b0),
        .pin_in(rst_in),
        .level_out(rst_s)
    );
    pin_sync #(.WIDTH(STATUS_W)) u_stat_sync (
        .clk_in(tck_in),
        .rst_in(rst_s),
        .pin_in({2'h0, link.state_code, link.user_mode,
                 link.error_seen, link.done_released}),
        .level_out(stat_s)
    );

    // next state, capture and shift path
    always_comb
    begin
        st_next = st_reg;
        ir_next = ir_reg;
        irsh_next = irsh_reg;
        dr_next = dr_reg;
        case (st_reg)
            TAP_RESET: st_next = tms_eff ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: st_next = tms_eff ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: st_next = tms_eff ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: st_next = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: st_next = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: st_next = tms_eff ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: st_next = tms_eff ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: st_next = tms_eff ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: st_next = tms_eff ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: st_next = tms_eff ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: st_next = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: st_next = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: st_next = tms_eff ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: st_next = tms_eff ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: st_next = tms_eff ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: st_next = tms_eff ? TAP_SEL_DR : TAP_IDLE;
            default: st_next = TAP_RESET;
        endcase
        if (st_reg == TAP_RESET)
            ir_next = IR_IDCODE;
        if (st_reg == TAP_CAP_IR)
            irsh_next = IR_CAPTURE;
        if (st_reg == TAP_SHIFT_IR)
            irsh_next = {tdi_eff, irsh_reg[IR_W-1:1]};
        if (st_reg == TAP_UPD_IR)
            ir_next = irsh_reg;
        if (st_reg == TAP_CAP_DR)
        begin
            case (ir_reg)
                IR_IDCODE: dr_next = IDCODE;
                IR_STATUS: dr_next = {24'h0, stat_s};
                default: dr_next = 32'h0;
            endcase
        end
        // the inserted bit lands at the selected register's length
        if (st_reg == TAP_SHIFT_DR)
        begin
            case (ir_reg)
                IR_IDCODE: dr_next = {tdi_eff, dr_reg[31:1]};
                IR_STATUS: dr_next = {24'h0, tdi_eff, dr_reg[7:1]};
                default: dr_next = {31'h0, tdi_eff};
            endcase
        end
    end

    // inputs taken on rising test clock
    always_ff @(posedge tck_in)
    begin
        if (rst_s)
        begin
            st_reg <= TAP_RESET;
            ir_reg <= IR_IDCODE;
            irsh_reg <= '0;
            dr_reg <= 32'h0;
        end
        else
        begin
            st_reg <= st_next;
            ir_reg <= ir_next;
            irsh_reg <= irsh_next;
            dr_reg <= dr_next;
        end
    end

    assign shift_bit = (st_reg == TAP_SHIFT_IR) ? irsh_reg[0] : dr_reg[0];

    // output moves on falling test clock
    always_ff @(negedge tck_in)
    begin
        if (rst_s)
        begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end
        else
        begin
            tdo_reg <= shift_bit;
            tdo_oe_reg <= (st_reg == TAP_SHIFT_IR) ||
                          (st_reg == TAP_SHIFT_DR);
        end
    end

    assign tdo_out = tdo_reg;
    assign tdo_oe_out = tdo_oe_reg;
endmodule : jtag_tap
`default_nettype wire

/* verilog/fpga_config_pin_control.sv */
// configuration controller with its pin roles and test access port
// What this block does
// - done flag open drain, high when complete
// - done held low keeps user mode off
// - reconfigure on request rising edge, not reset
// - tap samples tms and tdi rising
// - tap changes tdo after falling edge
// - tms and tdi read one when undriven
// - tdi routed to ir or dr
// - tdo released when not shifting
// - bus width from pulled-up select input in passive mode, fixed x1 in active mode
// - image select picks image when enabled
// - config clock input passive, output active
// - data pin roles swap with mode
// - chip select low ignores configuration
// - chip select output enables next device
// - error low on id, checksum, update failure
// - flash select sampled at request edge
// - reserved output high during configuration
// - dual-purpose pins released in user mode
// - dedicated pins keep configuration roles
`timescale 1ns/1ps
`default_nettype none
module fpga_config_pin_control
    import cfg_pkg::*;
#(
    parameter logic [15:0] PAYLOAD_WORDS = PAYLOAD_WORDS_DEF,
    parameter logic [31:0] EXPECTED_ID = EXPECTED_ID_DEF,
    parameter int CCLK_HALF = CCLK_HALF_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic done_pin_in,
    output logic done_out,
    output logic done_oe_out,
    input wire logic reconfig_n_in,
    input wire logic flash_select_in,
    output logic flash_select_out,
    output logic flash_select_oe_out,
    input wire logic chip_select_in,
    output logic chip_select_out,
    input wire logic [2:0] bus_width_select_in,
    input wire logic [2:0] bus_width_driven_in,
    input wire logic [1:0] image_select_in,
    input wire logic multi_image_en_in,
    input wire logic config_clock_in,
    output logic config_clock_out,
    output logic config_clock_oe_out,
    input wire logic [DATA_PINS-1:0] config_data_in,
    output logic [DATA_PINS-1:0] config_data_out,
    output logic [DATA_PINS-1:0] config_data_oe_out,
    input wire logic remote_update_fail_in,
    output logic config_error_n_out,
    output logic reserved_out,
    output logic user_mode_out,
    output logic gpio_release_out,
    output logic [WORD_W-1:0] config_word_out,
    output logic config_word_valid_out,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tms_driven_in,
    input wire logic tdi_in,
    input wire logic tdi_driven_in,
    output logic tdo_out,
    output logic tdo_oe_out
);
    localparam int DIV_W = $clog2(CCLK_HALF + 1) + 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CCLK_HALF - 1);

    tap_link_if link ();

    cfg_state_t st_reg, st_next;
    logic active_reg, active_next;
    logic [WORD_W-1:0] word_reg, word_next, sum_reg, sum_next;
    logic [5:0] bits_reg, bits_next;
    logic [15:0] idx_reg, idx_next;
    logic [WORD_W-1:0] cmd_reg, cmd_next;
    logic [5:0] cmd_cnt_reg, cmd_cnt_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic cclk_reg, cclk_next;
    logic cclk_prev_reg, req_prev_reg;
    logic err_n_reg, err_n_next;
    logic cso_reg, cso_next;
    logic [WORD_W-1:0] out_word_reg, out_word_next;
    logic out_valid_reg, out_valid_next;
    logic ok_id_reg, ok_id_next;

    logic req_s, fsel_s, cs_s, done_s, cclk_s;
    logic [2:0] width_s;
    logic [1:0] image_s;
    logic [DATA_PINS-1:0] data_s;
    logic req_rise, cclk_rise, div_tick, rise_tick, fall_tick, beat;
    logic [2:0] width_code;
    logic [5:0] width_bits;
    logic [WORD_W-1:0] chunk, width_mask, word_built;
    logic [6:0] bits_sum;
    logic [23:0] image_base;
    logic driving, in_user;

    // control, select and data pin levels pass the agreement filter
    pin_sync #(.WIDTH(5), .INIT(5'h19)) u_ctl_sync (
        .clk_in(clock_in),
        .rst_in(sys_rst_in),
        .pin_in({reconfig_n_in, flash_select_in, chip_select_in,
                 done_pin_in, config_clock_in}),
        .level_out({req_s, fsel_s, cs_s, done_s, cclk_s})
    );
    // weak pull-up on undriven width bits
    pin_sync #(.WIDTH(5), .INIT(5'h1C)) u_sel_sync (
        .clk_in(clock_in),
        .rst_in(sys_rst_in),
        .pin_in({bus_width_select_in | ~bus_width_driven_in,
                 image_select_in}),
        .level_out({width_s, image_s})
    );
    pin_sync #(.WIDTH(DATA_PINS)) u_data_sync (
        .clk_in(clock_in),
        .rst_in(sys_rst_in),
        .pin_in(config_data_in),
        .level_out(data_s)
    );

    // test port stays active in every state
    jtag_tap u_tap (
        .tck_in(tck_in),
        .rst_in(sys_rst_in),
        .tms_in(tms_in),
        .tms_driven_in(tms_driven_in),
        .tdi_in(tdi_in),
        .tdi_driven_in(tdi_driven_in),
        .link(link.tap),
        .tdo_out(tdo_out),
        .tdo_oe_out(tdo_oe_out)
    );

    // only the rising edge starts a load
    assign req_rise = req_s & ~req_prev_reg;
    assign cclk_rise = cclk_s & ~cclk_prev_reg;
    assign div_tick = (div_reg == DIV_LAST);
    assign rise_tick = div_tick & ~cclk_reg;
    assign fall_tick = div_tick & cclk_reg;

    // width codes above the maximum fall back to x1
    assign width_code = (width_s > WIDTH_CODE_MAX) ? 3'h0 : width_s;
    assign width_bits = active_reg ? 6'h01 : (6'h01 << width_code);
    assign width_mask = (width_bits == 6'h20) ? 32'hFFFF_FFFF :
                        ((32'h0000_0001 << width_bits) - 32'h0000_0001);
    // active mode reads pin one, passive reads from pin zero
    assign chunk = active_reg ? {31'h0, data_s[1]} : (data_s & width_mask);
    assign word_built = (word_reg << width_bits) | chunk;
    assign bits_sum = {1'b0, bits_reg} + {1'b0, width_bits};

    // no clock edges counted while deselected
    assign beat = (st_reg == ST_LOAD) && cs_s &&
                  (active_reg ? rise_tick : cclk_rise);

    // image base only when multi-image is enabled
    assign image_base = multi_image_en_in ?
                        (IMAGE_STRIDE * {22'h0, image_s}) : 24'h00_0000;

    // main sequence and word assembly
    always_comb
    begin
        st_next = st_reg;
        active_next = active_reg;
        word_next = word_reg;
        sum_next = sum_reg;
        bits_next = bits_reg;
        idx_next = idx_reg;
        cmd_next = cmd_reg;
        cmd_cnt_next = cmd_cnt_reg;
        div_next = div_reg;
        cclk_next = cclk_reg;
        err_n_next = err_n_reg;
        cso_next = cso_reg;
        out_word_next = out_word_reg;
        out_valid_next = 1'b0;
        ok_id_next = ok_id_reg;
        // the divider runs only while the flash is being read
        if (active_reg && (st_reg == ST_CMD || st_reg == ST_LOAD))
        begin
            div_next = div_tick ? '0 : div_reg + DIV_W'(1);
            cclk_next = div_tick ? ~cclk_reg : cclk_reg;
        end
        else
        begin
            div_next = '0;
            cclk_next = 1'b0;
        end
        case (st_reg)
            ST_IDLE: ;
            ST_CMD:
            begin
                // address bits leave on falling edges
                if (fall_tick)
                begin
                    cmd_next = {cmd_reg[WORD_W-2:0], 1'b0};
                    cmd_cnt_next = cmd_cnt_reg + 6'h01;
                    if (cmd_cnt_reg == 6'(FLASH_CMD_BITS - 1))
                        st_next = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                if (beat)
                begin
                    word_next = word_built;
                    bits_next = bits_sum[5:0];
                    if (bits_sum >= 7'(WORD_W))
                    begin
                        bits_next = 6'h00;
                        idx_next = idx_reg + 16'h0001;
                        if (idx_reg == 16'h0000)
                        begin
                            ok_id_next = (word_built == EXPECTED_ID);
                            if (word_built != EXPECTED_ID)
                                st_next = ST_FAIL;
                        end
                        else if (idx_reg <= PAYLOAD_WORDS)
                        begin
                            sum_next = sum_reg ^ word_built;
                            out_word_next = word_built;
                            out_valid_next = 1'b1;
                        end
                        else
                        begin
                            sum_next = sum_reg ^ word_built;
                            st_next = ST_CHECK;
                        end
                    end
                end
            end
            ST_CHECK:
            begin
                // release only with id and checksum good and no remote update failure
                if (ok_id_reg && sum_reg == 32'h0 && !remote_update_fail_in)
                    st_next = ST_RELEASE;
                else
                    st_next = ST_FAIL;
            end
            ST_RELEASE:
            begin
                // a pin held low keeps user mode off
                if (done_s)
                    st_next = ST_USER;
            end
            ST_USER:
            begin
                // a failed remote update is reported
                if (remote_update_fail_in)
                    st_next = ST_FAIL;
            end
            ST_FAIL: ;
            default: st_next = ST_IDLE;
        endcase
        // error low only in the failure state
        err_n_next = (st_next != ST_FAIL);
        // next device enabled once this one is done
        cso_next = (st_next == ST_RELEASE) || (st_next == ST_USER);
        // a new request overrides whatever is in progress
        if (!req_s)
            st_next = ST_IDLE;
        if (req_rise)
        begin
            // mode latched from the flash select pin
            active_next = fsel_s;
            st_next = fsel_s ? ST_CMD : ST_LOAD;
            word_next = 32'h0;
            sum_next = 32'h0;
            bits_next = 6'h00;
            idx_next = 16'h0000;
            ok_id_next = 1'b0;
            cmd_next = {FLASH_READ_CMD, image_base};
            cmd_cnt_next = 6'h00;
            err_n_next = 1'b1;
            cso_next = 1'b0;
        end
    end

    // registers of the main sequence
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            st_reg <= ST_IDLE;
            active_reg <= 1'b0;
            word_reg <= 32'h0;
            sum_reg <= 32'h0;
            bits_reg <= 6'h00;
            idx_reg <= 16'h0000;
            cmd_reg <= 32'h0;
            cmd_cnt_reg <= 6'h00;
            div_reg <= '0;
            cclk_reg <= 1'b0;
            cclk_prev_reg <= 1'b1;
            req_prev_reg <= 1'b1;
            err_n_reg <= ERROR_N_RST;
            cso_reg <= 1'b0;
            out_word_reg <= 32'h0;
            out_valid_reg <= 1'b0;
            ok_id_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            active_reg <= active_next;
            word_reg <= word_next;
            sum_reg <= sum_next;
            bits_reg <= bits_next;
            idx_reg <= idx_next;
            cmd_reg <= cmd_next;
            cmd_cnt_reg <= cmd_cnt_next;
            div_reg <= div_next;
            cclk_reg <= cclk_next;
            cclk_prev_reg <= cclk_s;
            req_prev_reg <= req_s;
            err_n_reg <= err_n_next;
            cso_reg <= cso_next;
            out_word_reg <= out_word_next;
            out_valid_reg <= out_valid_next;
            ok_id_reg <= ok_id_next;
        end
    end

    assign in_user = (st_reg == ST_USER);
    assign driving = active_reg && (st_reg == ST_CMD || st_reg == ST_LOAD);

    // pulled low until the checked load is released
    assign done_out = 1'b0;
    assign done_oe_out = !((st_reg == ST_RELEASE) || in_user);
    // clock pin driven only in active mode
    assign config_clock_out = cclk_reg;
    assign config_clock_oe_out = driving;
    // pin zero carries the flash command when active
    assign config_data_out = {31'h0, cmd_reg[WORD_W-1]};
    assign config_data_oe_out = {31'h0, driving};
    // select pin becomes an output in active mode
    assign flash_select_out = 1'b0;
    assign flash_select_oe_out = driving;
    assign chip_select_out = cso_reg;
    assign config_error_n_out = err_n_reg;
    // reserved pin is simply held high
    assign reserved_out = RESERVED_RST;
    assign user_mode_out = in_user;
    // dual-purpose pins handed to user logic
    assign gpio_release_out = in_user;
    assign config_word_out = out_word_reg;
    assign config_word_valid_out = out_valid_reg;

    // status toward the test clock domain, synchronised there
    assign link.done_released = cso_reg;
    assign link.error_seen = ~err_n_reg;
    assign link.user_mode = in_user;
    assign link.state_code = st_reg;
endmodule : fpga_config_pin_control
`default_nettype wire

/* bench/cfg_chk_sva.sv */
// checker on the configuration pins
`timescale 1ns/1ps
`default_nettype none
module cfg_chk (
    input wire logic clock_in, sys_rst_in, done_pin_in, done_oe_out,
    input wire logic config_clock_oe_out, flash_select_oe_out,
    input wire logic chip_select_out, config_error_n_out, reserved_out,
    input wire logic user_mode_out, gpio_release_out
);
    // one domain, so one clocking for all
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    rsv_high_a: assert property (reserved_out) else $error("rsv");
    gpio_user_a: assert property (gpio_release_out == user_mode_out)
        else $error("gpio");
    user_done_a: assert property (user_mode_out |-> !done_oe_out)
        else $error("done");
    done_err_a: assert property (!done_oe_out |-> config_error_n_out)
        else $error("err");
    user_pin_a: assert property ($rose(user_mode_out) |-> $past(done_pin_in))
        else $error("held");
    user_cso_a: assert property (user_mode_out |-> chip_select_out)
        else $error("cso");
    fail_hold_a: assert property ($fell(config_error_n_out) |-> done_oe_out)
        else $error("fail");
    user_free_a: assert property (user_mode_out |-> !(config_clock_oe_out ||
        flash_select_oe_out)) else $error("free");
    cover property ($rose(user_mode_out));
    cover property ($fell(config_error_n_out));
    cover property (!done_oe_out && !user_mode_out);
endmodule : cfg_chk
bind fpga_config_pin_control cfg_chk chk_u (.*);
`default_nettype wire

/* bench/cfg_host.sv */
// passive serial host and done pull-up
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    input wire logic clk_in, done_oe_in,
    output logic cclk_out, d0_out, rcfg_n_out, done_pin_out
);
    logic hold = 1'b0;
    initial {cclk_out, d0_out, rcfg_n_out} = 3'h5;
    // board pulls the done pin high unless it is driven low or hold is set
    assign done_pin_out = !done_oe_in && !hold;
    task automatic pulse;
        @(posedge clk_in) rcfg_n_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        rcfg_n_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask : pulse
    // msb first; long beats ride out the pin filter
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge clk_in) {cclk_out, d0_out} <= {1'b0, w[i]};
            repeat (6) @(posedge clk_in);
            cclk_out <= 1'b1;
            repeat (8) @(posedge clk_in);
        end
        d0_out <= ~w[0];
    endtask : send
endmodule : cfg_host
`default_nettype wire

/* bench/tb.sv */
// top bench of the configuration pin controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
$display("Error %s exp %h got %h", n, e, g); end end
module tb;
    logic clock_in = 1'b0, rst = 1'b1, cs = 1'b1, tck = 1'b0, tms = 1'b1;
    logic done_oe, err_n, user, gpio, chip_select_output, tdo, tdo_oe, cck_oe, fs_oe;
    logic fsel = 1'b0, rfail = 1'b0, multi = 1'b0, tdi = 1'b0, tdi_drv = 1'b0;
    logic [31:0] word;
    wire logic cclk, d0, rcfg_n, done_pin;
    int error_cnt = 0, compares = 0;
    localparam logic [31:0] P = 32'hC3A5_0F96;
    fpga_config_pin_control #(.PAYLOAD_WORDS(16'h0001)) dut_u (
        .clock_in(clock_in), .sys_rst_in(rst), .done_pin_in(done_pin),
        .done_out(), .done_oe_out(done_oe), .reconfig_n_in(rcfg_n),
        .flash_select_in(fsel), .flash_select_out(),
        .flash_select_oe_out(fs_oe), .chip_select_in(cs),
        .chip_select_out(chip_select_output), .image_select_in(2'h0),
        .bus_width_select_in(3'h0), .bus_width_driven_in(3'h0),
        .multi_image_en_in(multi), .config_clock_in(cclk),
        .config_clock_out(), .config_clock_oe_out(cck_oe),
        .config_data_out(), .config_data_in({31'h0, d0}),
        .config_data_oe_out(), .remote_update_fail_in(rfail),
        .config_error_n_out(err_n), .reserved_out(), .user_mode_out(user),
        .gpio_release_out(gpio), .config_word_out(word),
        .config_word_valid_out(), .tck_in(tck), .tms_in(tms),
        .tms_driven_in(1'b1), .tdi_in(tdi), .tdi_driven_in(tdi_drv),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe));
    cfg_host host_u (.clk_in(clock_in), .done_oe_in(done_oe),
        .cclk_out(cclk), .d0_out(d0), .rcfg_n_out(rcfg_n),
        .done_pin_out(done_pin));
    task automatic give_verdict;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    // id, one payload word, checksum
    task automatic frame(input logic [31:0] c);
        host_u.pulse();
        host_u.send(cfg_pkg::EXPECTED_ID_DEF);
        host_u.send(P);
        if (cs) `CHK("word", P, word)
        host_u.send(c);
        repeat (12) @(posedge clock_in);
    endtask : frame
    // tester moves tms after the falling edge
    task automatic tk(input logic m);
        tms <= m;
        @(negedge tck);
        #5;
    endtask : tk
    task automatic t_good;
        host_u.hold <= 1'b1;
        frame(P);
        `CHK("user", 1'b0, user)
        `CHK("done_oe", 1'b0, done_oe)
        host_u.hold <= 1'b0;
        repeat (12) @(posedge clock_in);
        `CHK("user", 1'b1, user)
        `CHK("gpio", 1'b1, gpio)
        `CHK("cso", 1'b1, chip_select_output)
        // a failed remote update drops out of user mode
        rfail <= 1'b1;
        @(posedge clock_in) rfail <= 1'b0;
        repeat (2) @(posedge clock_in);
        `CHK("err_n", 1'b0, err_n)
        `CHK("user", 1'b0, user)
        $display("t_good ends");
    endtask : t_good
    task automatic t_crc;
        frame(P ^ 32'h1);
        `CHK("err_n", 1'b0, err_n)
        `CHK("done_oe", 1'b1, done_oe)
        `CHK("user", 1'b0, user)
        $display("t_crc ends");
    endtask : t_crc
    task automatic t_cs;
        cs <= 1'b0;
        frame(P);
        `CHK("user", 1'b0, user)
        `CHK("err_n", 1'b1, err_n)
        cs <= 1'b1;
        $display("t_cs ends");
    endtask : t_cs
    // select pin sampled at the request edge picks the mode
    task automatic t_act;
        fsel <= 1'b1;
        host_u.pulse();
        `CHK("fs_oe", 1'b1, fs_oe)
        `CHK("cck_oe", 1'b1, cck_oe)
        fsel <= 1'b0;
        host_u.pulse();
        `CHK("fs_oe", 1'b0, fs_oe)
        `CHK("cck_oe", 1'b0, cck_oe)
        $display("t_act ends");
    endtask : t_act
    // reset, then into shift-ir; capture reads 0001 lsb first
    task automatic t_tap;
        @(negedge tck);
        #5;
        for (int i = 0; i < 12; i++)
            tk(12'h37F >> i);
        `CHK("tdo_oe", 1'b1, tdo_oe)
        `CHK("tdo", 1'b1, tdo)
        tk(1'b0);
        `CHK("tdo", 1'b0, tdo)
        // the pulled-up tdi bit emerges after four shifts
        repeat (3) tk(1'b0);
        `CHK("tdo", 1'b1, tdo)
        tk(1'b1);
        `CHK("tdo_oe", 1'b0, tdo_oe)
        $display("t_tap ends");
    endtask : t_tap
    initial forever #4 clock_in = ~clock_in;
    // free-running test clock, offset from the system clock
    initial #3 forever #80 tck = ~tck;
    initial
    begin
        repeat (16) @(posedge clock_in);
        rst <= 1'b0;
        t_good;
        t_crc;
        t_cs;
        t_act;
        t_tap;
        give_verdict;
    end
    // runs take about 39 us
    initial
    begin
        #300000;
        error_cnt++;
        give_verdict;
    end
endmodule : tb
`default_nettype wire
